// file: core/dtb_pkg.sv
package dtb_pkg;

    // APB register byte offsets
    localparam logic [7:0] DTB_REG_CTRL    = 8'h00;
    localparam logic [7:0] DTB_REG_STATUS  = 8'h04;
    localparam logic [7:0] DTB_REG_MASK    = 8'h08;
    localparam logic [7:0] DTB_REG_BASE    = 8'h0c;
    localparam logic [7:0] DTB_REG_TIMEOUT = 8'h10;
    localparam logic [7:0] DTB_REG_RDATA   = 8'h14;
    localparam logic [7:0] DTB_REG_WDATA   = 8'h18;
    localparam logic [7:0] DTB_REG_ADDR    = 8'h1c;
    localparam logic [7:0] DTB_REG_AM      = 8'h20;
    localparam logic [7:0] DTB_REG_COUNT   = 8'h24;

    // CTRL field positions
    localparam int DTB_CTL_ENABLE   = 0;
    localparam int DTB_CTL_WIDTH_LO = 1;
    localparam int DTB_CTL_A16      = 3;
    localparam int DTB_CTL_A24      = 4;
    localparam int DTB_CTL_A32      = 5;
    localparam int DTB_CTL_USE_AS   = 6;
    localparam int DTB_CTL_BERR_DRV = 7;
    localparam int DTB_CTL_TMR_EN   = 8;
    localparam int DTB_CTL_TMR_COND = 9;
    localparam int DTB_CTL_BITS     = 10;

    // STATUS / MASK bit positions
    localparam int DTB_ST_CLAIM    = 0;
    localparam int DTB_ST_WRITE    = 1;
    localparam int DTB_ST_TIMEOUT  = 2;
    localparam int DTB_ST_MONITOR  = 3;
    localparam int DTB_ST_SLV_ERR  = 4;
    localparam int DTB_ST_BITS     = 5;

    // Reset values
    localparam logic [DTB_CTL_BITS-1:0] DTB_CTRL_RST    = 10'h000;
    localparam logic [31:0]             DTB_BASE_RST    = 32'h0000_0000;
    localparam logic [15:0]             DTB_TIMEOUT_RST = 16'h0040;

    // Timer tick: one microsecond of a 40 ns clock
    localparam int DTB_CLK_NS     = 40;
    localparam int DTB_TICK_NS    = 1000;
    localparam int DTB_CYC_PER_US = DTB_TICK_NS / DTB_CLK_NS;

    // Address-modifier codes per address width (defaults, adjustable)
    localparam logic [5:0] DTB_AM_A16_U = 6'h29;
    localparam logic [5:0] DTB_AM_A16_S = 6'h2d;
    localparam logic [5:0] DTB_AM_A24_U = 6'h39;
    localparam logic [5:0] DTB_AM_A24_S = 6'h3d;
    localparam logic [5:0] DTB_AM_A32_U = 6'h09;
    localparam logic [5:0] DTB_AM_A32_S = 6'h0d;

    typedef enum logic [1:0] {
        DTB_W_D08O,
        DTB_W_D08EO,
        DTB_W_D16,
        DTB_W_D32
    } dtb_width_e;

    typedef enum logic [1:0] {
        DTB_AW_NONE,
        DTB_AW_SHORT,
        DTB_AW_STD,
        DTB_AW_EXT
    } dtb_aw_e;

    typedef enum logic [1:0] {
        DTB_IDLE,
        DTB_PLACE,
        DTB_ACK,
        DTB_WAIT_REL
    } dtb_fsm_e;

    // Backplane inputs, all active-low lines as seen on the wire
    typedef struct packed {
        logic [31:1] addr;
        logic [5:0]  am;
        logic        as_n;
        logic        ds0_n;
        logic        ds1_n;
        logic        lword_n;
        logic        write_n;
        logic        iack_n;
        logic        dtack_n;
        logic        berr_n;
        logic [31:0] data;
    } dtb_pins_s;

    // Backplane drivers: output value per pin, enable per pin or per data byte lane
    typedef struct packed {
        logic [31:0] data_o;
        logic [3:0]  data_oe;
        logic        dtack_n_o;
        logic        dtack_oe;
        logic        berr_n_o;
        logic        berr_oe;
    } dtb_drv_s;

endpackage

// file: core/dtb_slave_timer.sv
// Functional notes
// - Odd-byte-only mode samples and drives data lines 0 to 7 only.
// - Even-odd byte and 16-bit modes use data lines 0 to 15.
// - 32-bit mode samples and drives all thirty-two data lines.
// - Address may be captured on first data strobe instead of address strobe.
// - Short addresses compare address lines 1 to 15.
// - Standard addresses compare address lines 1 to 23.
// - Extended addresses compare address lines 1 to 31.
// - Location monitor watches the lines matching the address width.
// - Bus error driver is optional for refused quad requests; the timer drives bus error even when it is disabled.
// - All modifier lines decoded to tell the address widths apart.
// - Timer drives bus error when first data strobe stays low too long.
// - Unconditional timer fires regardless of acknowledge and error levels.
// - Conditional timer fires only if acknowledge and error are high.
// - Cycles with interrupt-acknowledge low are neither claimed nor monitored.
// - Acknowledge driven low after write data taken or read data placed.
`timescale 1ns/10ps
module dtb_slave_timer #(
    parameter int TICK_CYCLES = dtb_pkg::DTB_CYC_PER_US
) (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic                    irq,
    input  wire dtb_pkg::dtb_pins_s pins_in,
    output dtb_pkg::dtb_drv_s       pins_out
);
    import dtb_pkg::*;

    if (TICK_CYCLES < 1 || TICK_CYCLES > 255) begin : g_chk
        $error("TICK_CYCLES must be 1 to 255");
    end

    // Register fields must fit one bus word
    if (DTB_CTL_BITS > 32 || DTB_ST_BITS > 32) begin : g_chk_bits
        $error("Register fields wider than the bus word");
    end

    // Shared codes across widths would make the decode ambiguous
    if (DTB_AM_A16_U == DTB_AM_A24_U || DTB_AM_A16_U == DTB_AM_A32_U ||
        DTB_AM_A24_U == DTB_AM_A32_U || DTB_AM_A16_S == DTB_AM_A24_S ||
        DTB_AM_A16_S == DTB_AM_A32_S ||
        DTB_AM_A24_S == DTB_AM_A32_S) begin : g_chk_am
        $error("Modifier codes of two widths coincide");
    end

    // Every named bit must lie inside its register
    if (DTB_CTL_TMR_COND >= DTB_CTL_BITS ||
        DTB_ST_SLV_ERR >= DTB_ST_BITS) begin : g_chk_pos
        $error("Field position outside its register");
    end

    typedef struct packed {
        dtb_pins_s                sync1;
        dtb_pins_s                sync2;
        logic                     as_prev;
        logic                     ds_prev;
        logic [31:1]              as_addr;
        logic [DTB_CTL_BITS-1:0]  ctrl;
        logic [DTB_ST_BITS-1:0]   status;
        logic [DTB_ST_BITS-1:0]   mask;
        logic [31:0]              base;
        logic [15:0]              timeout;
        logic [31:0]              rdata;
        logic [31:0]              wdata;
        logic [31:1]              addr;
        logic [5:0]               am;
        dtb_fsm_e                 fsm;
        logic [7:0]               tick;
        logic [15:0]              count;
        logic                     fired;
        logic                     slv_err;
        logic [31:0]              prdata;
        logic                     pready;
        logic                     pslverr;
        logic                     irq;
        dtb_drv_s                 drv;
    } dtb_state_s;

    dtb_state_s st;
    dtb_state_s next_st;

    // Modifier code to address width
    function automatic dtb_aw_e am_width(input logic [5:0] am);
        unique case (am)
            DTB_AM_A16_U, DTB_AM_A16_S: am_width = DTB_AW_SHORT;
            DTB_AM_A24_U, DTB_AM_A24_S: am_width = DTB_AW_STD;
            DTB_AM_A32_U, DTB_AM_A32_S: am_width = DTB_AW_EXT;
            default:                    am_width = DTB_AW_NONE;
        endcase
    endfunction

    // Address lines significant for a width
    function automatic logic [31:1] aw_mask(input dtb_aw_e aw);
        unique case (aw)
            DTB_AW_SHORT: aw_mask = {16'h0000, 15'h7fff};
            DTB_AW_STD:   aw_mask = {8'h00, 23'h7f_ffff};
            DTB_AW_EXT:   aw_mask = 31'h7fff_ffff;
            DTB_AW_NONE:  aw_mask = 31'h0000_0000;
        endcase
    endfunction

    // Width accepted only if software enabled it
    function automatic logic aw_enabled(input dtb_aw_e aw,
                                        input logic [DTB_CTL_BITS-1:0] c);
        unique case (aw)
            DTB_AW_SHORT: aw_enabled = c[DTB_CTL_A16];
            DTB_AW_STD:   aw_enabled = c[DTB_CTL_A24];
            DTB_AW_EXT:   aw_enabled = c[DTB_CTL_A32];
            DTB_AW_NONE:  aw_enabled = 1'b0;
        endcase
    endfunction

    // Byte lanes served by each data width
    function automatic logic [3:0] lanes(input dtb_width_e w);
        unique case (w)
            DTB_W_D08O:  lanes = 4'h1;
            DTB_W_D08EO: lanes = 4'h3;
            DTB_W_D16:   lanes = 4'h3;
            DTB_W_D32:   lanes = 4'hf;
        endcase
    endfunction

    // Expand lane enables into a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] l);
        lane_mask = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
    endfunction

    logic        ds_low;
    logic        ds_fall;
    logic        as_fall;
    logic [31:1] cyc_addr;
    dtb_aw_e     cyc_aw;
    logic [31:1] cyc_mask;
    logic        win_hit;
    logic        claim;
    logic        quad_bad;
    dtb_width_e  width;
    logic [3:0]  ln;
    logic        apb_take;
    logic        apb_wr;
    logic [DTB_ST_BITS-1:0] ev;

    always_comb begin
        next_st = st;
        ev      = '0;
        width   = dtb_width_e'(st.ctrl[DTB_CTL_WIDTH_LO +: 2]);
        ln      = lanes(width);

        // Two-flop synchroniser; only the second stage is read
        next_st.sync1 = pins_in;
        next_st.sync2 = st.sync1;

        // Edge detectors idle at the released level of the pins
        ds_low  = !st.sync2.ds0_n || !st.sync2.ds1_n;
        ds_fall = ds_low && !st.ds_prev;
        as_fall = !st.sync2.as_n && st.as_prev;
        next_st.ds_prev = ds_low;
        next_st.as_prev = st.sync2.as_n;
        if (as_fall) begin
            next_st.as_addr = st.sync2.addr;
        end

        // address from strobe edge unless address strobe used
        cyc_addr = st.ctrl[DTB_CTL_USE_AS] ? st.as_addr : st.sync2.addr;
        cyc_aw   = am_width(st.sync2.am);
        cyc_mask = aw_mask(cyc_aw);
        win_hit  = cyc_aw != DTB_AW_NONE &&
                   ((cyc_addr ^ st.base[31:1]) & cyc_mask) == '0;
        // claim needs enabled width and window hit
        claim    = st.ctrl[DTB_CTL_ENABLE] && st.sync2.iack_n &&
                   aw_enabled(cyc_aw, st.ctrl) && win_hit;
        // Quad request to a narrow responder is refused
        quad_bad = !st.sync2.lword_n && width != DTB_W_D32;

        unique case (st.fsm)
            DTB_IDLE: begin
                if (ds_fall) begin
                    // Address and modifier kept for software
                    next_st.addr = cyc_addr;
                    next_st.am   = st.sync2.am;
                    if (win_hit && st.sync2.iack_n) begin
                        ev[DTB_ST_MONITOR] = 1'b1;
                    end
                    if (claim && quad_bad) begin
                        ev[DTB_ST_SLV_ERR] = 1'b1;
                        // error driven only when driver enabled
                        next_st.slv_err = st.ctrl[DTB_CTL_BERR_DRV];
                        next_st.fsm     = DTB_WAIT_REL;
                    end else if (claim) begin
                        ev[DTB_ST_CLAIM] = 1'b1;
                        if (!st.sync2.write_n) begin
                            ev[DTB_ST_WRITE] = 1'b1;
                            next_st.wdata = st.sync2.data & lane_mask(ln);
                        end else begin
                            next_st.drv.data_o  = st.rdata & lane_mask(ln);
                            next_st.drv.data_oe = ln;
                        end
                        next_st.fsm = DTB_PLACE;
                    end else begin
                        next_st.fsm = DTB_WAIT_REL;
                    end
                end
            end
            DTB_PLACE: begin
                // acknowledge after data settled one cycle
                next_st.drv.dtack_oe = 1'b1;
                next_st.fsm          = DTB_ACK;
            end
            // Hold drive until the master lets go of the strobe
            DTB_ACK, DTB_WAIT_REL: begin
                if (!ds_low) begin
                    next_st.drv.dtack_oe = 1'b0;
                    next_st.drv.data_oe  = 4'h0;
                    next_st.slv_err      = 1'b0;
                    next_st.fsm          = DTB_IDLE;
                end
            end
        endcase


        // count in ticks of local clock, clear on release
        if (!ds_low) begin
            next_st.tick  = '0;
            next_st.count = '0;
            next_st.fired = 1'b0;
        end else if (st.tick == 8'(TICK_CYCLES - 1)) begin
            next_st.tick = '0;
            // Saturate so a stuck strobe cannot wrap below timeout
            if (st.count != 16'hffff) begin
                next_st.count = st.count + 16'h0001;
            end
        end else begin
            next_st.tick = st.tick + 8'h01;
        end
        // Whole ticks only, so resolution is one tick
        // strobe low longer than timeout
        if (ds_low && st.ctrl[DTB_CTL_TMR_EN] && !st.fired &&
            st.count > st.timeout) begin
            // conditional variant checks both lines high
            if (!st.ctrl[DTB_CTL_TMR_COND] ||
                (st.sync2.dtack_n && st.sync2.berr_n)) begin
                next_st.fired       = 1'b1;
                ev[DTB_ST_TIMEOUT] = 1'b1;
            end
        end

        // Open-drain pins only ever pull low
        next_st.drv.berr_oe   = next_st.fired || next_st.slv_err;
        next_st.drv.dtack_n_o = 1'b0;
        next_st.drv.berr_n_o  = 1'b0;

        // APB: one wait state, write lands when pready is seen
        apb_take = psel && penable && !st.pready;
        apb_wr   = psel && penable && st.pready && pwrite;
        next_st.pready = apb_take;
        // Answer stands one cycle only, like pready
        next_st.pslverr = 1'b0;
        next_st.prdata  = 32'h0000_0000;
        if (apb_take) begin
            next_st.pslverr = 1'b0;
            unique case (paddr)
                DTB_REG_CTRL:    next_st.prdata = 32'(st.ctrl);
                DTB_REG_STATUS:  next_st.prdata = 32'(st.status);
                DTB_REG_MASK:    next_st.prdata = 32'(st.mask);
                DTB_REG_BASE:    next_st.prdata = st.base;
                DTB_REG_TIMEOUT: next_st.prdata = 32'(st.timeout);
                DTB_REG_RDATA:   next_st.prdata = st.rdata;
                DTB_REG_WDATA:   next_st.prdata = st.wdata;
                DTB_REG_ADDR:    next_st.prdata = {st.addr, 1'b0};
                DTB_REG_AM:      next_st.prdata = 32'(st.am);
                DTB_REG_COUNT:   next_st.prdata = 32'(st.count);
                default: begin
                    next_st.prdata  = 32'h0000_0000;
                    next_st.pslverr = 1'b1;
                end
            endcase
        end

        if (apb_wr) begin
            unique case (paddr)
                DTB_REG_CTRL:    next_st.ctrl    = pwdata[DTB_CTL_BITS-1:0];
                DTB_REG_MASK:    next_st.mask    = pwdata[DTB_ST_BITS-1:0];
                DTB_REG_BASE:    next_st.base    = pwdata;
                DTB_REG_TIMEOUT: next_st.timeout = pwdata[15:0];
                DTB_REG_RDATA:   next_st.rdata   = pwdata;
                default: begin
                end
            endcase
        end

        // Set wins over a same-cycle write-one clear
        next_st.status = st.status;
        if (apb_wr && paddr == DTB_REG_STATUS) begin
            next_st.status = st.status & ~pwdata[DTB_ST_BITS-1:0];
        end
        next_st.status = next_st.status | ev;
        next_st.irq    = |(next_st.status & next_st.mask);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st         <= '0;
            // Synchronisers preload the released level
            st.sync1   <= '1;
            st.sync2   <= '1;
            st.as_prev <= 1'b1;
            st.ctrl    <= DTB_CTRL_RST;
            st.base    <= DTB_BASE_RST;
            st.timeout <= DTB_TIMEOUT_RST;
            st.fsm     <= DTB_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign prdata   = st.prdata;
    assign pready   = st.pready;
    assign pslverr  = st.pslverr;
    assign irq      = st.irq;
    assign pins_out = st.drv;

endmodule // dtb_slave_timer

// file: test/dtb_bus_master.sv
`timescale 1ns/10ps
module dtb_bus_master
    import dtb_pkg::*;
(
    input  wire logic     clk,
    input  wire dtb_drv_s drv,
    output dtb_pins_s     pins
);
    dtb_pins_s m = '1;

    // Terminators pull every released line high
    always_comb begin
        pins = m;
        pins.dtack_n = !(drv.dtack_oe === 1'b1);
        pins.berr_n = !(drv.berr_oe === 1'b1);
        for (int l = 0; l < 4; l++) begin
            if (drv.data_oe[l] === 1'b1) begin
                pins.data[8*l+:8] = drv.data_o[8*l+:8];
            end
        end
    end

    // modifier goes out with every address
    task automatic cycle(input logic [31:1] a, input logic [5:0] am,
                         input logic wr, lw, ia, input logic [31:0] wd,
                         input int hold, output logic ack, berr,
                         output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        m.addr <= a;
        m.am <= am;
        m.iack_n <= ia;
        m.write_n <= !wr;
        m.lword_n <= lw;
        m.as_n <= 1'b0;
        m.data <= wr ? wd : '1;
        @(posedge clk);
        m.ds0_n <= 1'b0;
        m.ds1_n <= 1'b0;
        while (pins.dtack_n && pins.berr_n && n < 40) begin
            @(posedge clk);
            n++;
        end
        ack = !pins.dtack_n;
        berr = !pins.berr_n;
        rd = pins.data;
        // Slow master: strobes kept low to let the timer run
        repeat (hold) begin
            @(posedge clk);
            berr |= !pins.berr_n;
        end
        // Whole request released at once; terminators hold it high
        m <= '1;
        n = 0;
        while ((!pins.dtack_n || !pins.berr_n) && n < 40) begin
            @(posedge clk);
            n++;
        end
    endtask
endmodule // dtb_bus_master

// file: test/dtb_slave_timer_assertions.sv
`timescale 1ns/10ps
module dtb_sva
    import dtb_pkg::*;
#(
    parameter int TICK_CYCLES = 25
) (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire dtb_pins_s   pins_in,
    input wire dtb_drv_s    pins_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic ds_lo;
    assign ds_lo = !pins_in.ds0_n || !pins_in.ds1_n;

    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("long pready");
    property p_answer;
        psel && penable && !pready |=> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("late pready");
    property p_err_data;
        pready && pslverr |-> prdata == 32'h0;
    endproperty
    a_err_data: assert property (p_err_data) else $error("error data");
    property p_iack;
        !pins_in.iack_n [*6] |-> !pins_out.dtack_oe && pins_out.data_oe == 4'h0;
    endproperty
    a_iack: assert property (p_iack) else $error("iack answered");
    property p_ack_data;
        $rose(pins_out.dtack_oe) && pins_in.write_n |-> $past(pins_out.data_oe) != 4'h0;
    endproperty
    a_ack_data: assert property (p_ack_data) else $error("ack no data");
    property p_drive_read;
        pins_out.data_oe != 4'h0 |-> pins_in.write_n;
    endproperty
    a_drive_read: assert property (p_drive_read) else $error("drive");
    property p_release;
        !ds_lo [*5] |-> !pins_out.dtack_oe && !pins_out.berr_oe;
    endproperty
    a_release: assert property (p_release) else $error("no release");
    property p_berr_strobe;
        $rose(pins_out.berr_oe) |-> $past(ds_lo, 2) || $past(ds_lo, 3);
    endproperty
    a_berr_strobe: assert property (p_berr_strobe) else $error("berr");
    property p_od_level;
        pins_out.dtack_oe || pins_out.berr_oe |->
            !pins_out.dtack_n_o && !pins_out.berr_n_o;
    endproperty
    a_od_level: assert property (p_od_level) else $error("drive high");

    c_ack: cover property (pins_out.dtack_oe);
    c_berr: cover property (pins_out.berr_oe);
    c_slverr: cover property (pready && pslverr);
endmodule // dtb_sva

bind dtb_slave_timer dtb_sva #(.TICK_CYCLES(TICK_CYCLES)) i_sva (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .pins_in(pins_in), .pins_out(pins_out));

// file: test/tb.sv
`timescale 1ns/10ps
module tb;
    import dtb_pkg::*;
    localparam logic [31:0] B = 32'h8a5c3d46;
    localparam logic [31:0] D = 32'hc3a55a3c;
    // Flags: write, lword_n, ack, berr, monitor hit
    typedef struct {
        logic [9:0]  ctrl;
        logic [5:0]  am;
        logic [31:0] x;
        logic [31:0] mask;
        logic [4:0]  f;
    } dtb_row_s;
    dtb_row_s rows[14] = '{
        '{10'h03f, 6'h09, 32'h0, 32'hffffffff, 5'h05},
        '{10'h03f, 6'h0d, 32'h0, 32'hffffffff, 5'h15},
        '{10'h03d, 6'h39, 32'h0, 32'h0000ffff, 5'h0d},
        '{10'h03d, 6'h2d, 32'h0, 32'h0000ffff, 5'h1d},
        '{10'h039, 6'h29, 32'h0, 32'h000000ff, 5'h0d},
        '{10'h03f, 6'h3f, 32'h0, 32'hffffffff, 5'h08},
        '{10'h03f, 6'h39, 32'h00800000, 32'hffffffff, 5'h08},
        '{10'h03f, 6'h29, 32'h00008000, 32'hffffffff, 5'h08},
        '{10'h03f, 6'h09, 32'h80000000, 32'hffffffff, 5'h00},
        '{10'h01f, 6'h09, 32'h0, 32'hffffffff, 5'h01},
        '{10'h03f, 6'h29, 32'h00010000, 32'hffffffff, 5'h0d},
        '{10'h0bd, 6'h09, 32'h0, 32'hffffffff, 5'h03},
        '{10'h03d, 6'h09, 32'h0, 32'hffffffff, 5'h01},
        '{10'h07f, 6'h09, 32'h0, 32'hffffffff, 5'h05}};
    logic        clk, reset, psel, penable, pwrite, pready, pslverr, irq;
    logic        ack, berr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, got;
    dtb_pins_s   pins;
    dtb_drv_s    drv;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          cyc = 0;

    dtb_slave_timer #(.TICK_CYCLES(1)) i_dut (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .pins_in(pins), .pins_out(drv));
    dtb_bus_master i_mst (.clk(clk), .drv(drv), .pins(pins));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic end_sim();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No cycle count assumed; only the bench timeout ends a hang
        do begin
            @(posedge clk);
        end while (!pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic bus(input logic [5:0] am, input logic lw, ia, input int h);
        i_mst.cycle(B[31:1], am, 1'b0, lw, ia, D, h, ack, berr, got);
    endtask

    initial begin
        reset = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        apb(1'b0, DTB_REG_CTRL, 32'h0);
        chk(rd, {22'h0, DTB_CTRL_RST});
        apb(1'b0, DTB_REG_TIMEOUT, 32'h0);
        chk(rd, {16'h0, DTB_TIMEOUT_RST});
        apb(1'b1, DTB_REG_BASE, B);
        apb(1'b1, DTB_REG_RDATA, D);
        foreach (rows[i]) begin
            apb(1'b1, DTB_REG_CTRL, {22'h0, rows[i].ctrl});
            i_mst.cycle(B[31:1] ^ rows[i].x[31:1], rows[i].am, rows[i].f[4],
                        rows[i].f[3], 1'b1, D, 0, ack, berr, got);
            chk({ack, berr}, rows[i].f[2:1]);
            if (ack && !rows[i].f[4]) begin
                chk(got, D & rows[i].mask | ~rows[i].mask);
            end
            if (ack && rows[i].f[4]) begin
                apb(1'b0, DTB_REG_WDATA, 32'h0);
                chk(rd & rows[i].mask, D & rows[i].mask);
            end
            apb(1'b0, DTB_REG_STATUS, 32'h0);
            // Quad to a narrow width flags a slave error when the cycle is claimed
            chk(rd & 32'h18, {!rows[i].f[3] && rows[i].ctrl[2:1] != 2'h3,
                              rows[i].f[0], 3'h0});
            apb(1'b1, DTB_REG_STATUS, 32'h1f);
        end
        apb(1'b1, DTB_REG_CTRL, 32'h03f);
        bus(6'h09, 1'b0, 1'b0, 0);
        chk(ack, 1'b0);
        apb(1'b0, 8'h3c, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, DTB_REG_MASK, 32'h8);
        bus(6'h09, 1'b0, 1'b1, 0);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        apb(1'b1, DTB_REG_MASK, 32'h0);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        apb(1'b1, DTB_REG_MASK, 32'h8);
        apb(1'b1, DTB_REG_STATUS, 32'h8);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        apb(1'b1, DTB_REG_TIMEOUT, 32'h4);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, DTB_REG_CTRL, 32'h13f | (k << 9));
            bus(6'h3f, 1'b1, 1'b1, 0);
            chk(berr, 1'b1);
            bus(6'h09, 1'b0, 1'b1, 30);
            chk({ack, berr}, {1'b1, k == 0});
        end
        apb(1'b0, DTB_REG_STATUS, 32'h0);
        chk(rd[DTB_ST_TIMEOUT], 1'b1);
        end_sim();
    end
endmodule // tb
